/* logic/mch_pkg.sv */
package mch_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    // Unattended-answer abandon time, seconds
    localparam int unsigned NO_CARRIER_S = 30;
    localparam int unsigned NO_CARRIER_MS = NO_CARRIER_S * 1000;
    // Marking hold before request-to-send drops, ms
    localparam int unsigned MARK_HOLD_MS = 15;
    // Request-to-send to terminal-ready drop spacing, ms
    localparam int unsigned RTS_TO_DTR_MS = 15;
    // Echo-suppressor disable tone length, ms (centre of 300 +/- 50)
    localparam int unsigned TONE_MS = 300;
    // Longest permitted silence after suppressors are disabled, ms
    localparam int unsigned SILENCE_MAX_MS = 100;
    // Keep-alive margin: reverse channel starts well before the limit
    localparam int unsigned KEEPALIVE_MS = SILENCE_MAX_MS / 2;
    localparam int unsigned MS_W = 16;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        MCH_IDLE = 4'h0,
        MCH_ANSWER = 4'h1,
        MCH_WAIT_CTS = 4'h2,
        MCH_SEND = 4'h3,
        MCH_RECEIVE = 4'h4,
        MCH_TURN_MARK = 4'h5,
        MCH_HANGUP_MARK = 4'h6,
        MCH_HANGUP_GAP = 4'h7,
        MCH_TONE = 4'h8
    } mch_state_e;

    // Leads from the modem
    typedef struct packed {
        logic ring;
        logic set_ready;
        logic clear_to_send;
        logic carrier_detect;
        logic supervisory_rx;
    } mch_modem_in_s;

    // Leads to the modem
    typedef struct packed {
        logic terminal_ready;
        logic request_to_send;
        logic tx_marking;
        logic supervisory_tx;
        logic tone_2025;
    } mch_modem_out_s;

    // Requests from the terminal logic
    typedef struct packed {
        logic auto_answer;
        logic send_first;
        logic reverse_channel;
        logic gate_on_supervisory;
        logic msg_done;
        logic end_of_message_code_received;
        logic hangup;
        logic call_out;
    } mch_req_s;

    // Status to the terminal logic
    typedef struct packed {
        logic may_send;
        logic in_call;
        logic abandoned;
        logic ring_seen;
    } mch_stat_s;

endpackage : mch_pkg

/* logic/mch_sequencer.sv */
`timescale 1ns/1ps
module mch_sequencer #(
    parameter int unsigned CLK_PER_MS = mch_pkg::CLK_PER_MS,
    parameter int unsigned NO_CARRIER_MS = mch_pkg::NO_CARRIER_MS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire mch_pkg::mch_modem_in_s modem_in,
    input wire mch_pkg::mch_req_s req,
    output mch_pkg::mch_modem_out_s modem_out,
    output mch_pkg::mch_stat_s stat
);

    initial begin
        if (CLK_PER_MS < 2 || CLK_PER_MS > 65535) begin
            $error("CLK_PER_MS out of range");
        end
        if (NO_CARRIER_MS < 1 || NO_CARRIER_MS > 65535) begin
            $error("NO_CARRIER_MS out of range");
        end
    end

    // ---------------------------------------------------------------
    // State record
    // ---------------------------------------------------------------
    typedef struct packed {
        mch_pkg::mch_state_e state;
        logic [15:0] div;
        logic [mch_pkg::MS_W-1:0] ms;
        logic [mch_pkg::MS_W-1:0] quiet_ms;
        logic carrier_seen;
        logic suppressors_off;
        logic ring_prev;
        mch_pkg::mch_modem_out_s out;
        mch_pkg::mch_stat_s st;
    } mch_reg_s;

    mch_reg_s r;
    mch_reg_s next_r;
    logic tick;

    // Counter with saturation, one step per millisecond tick
    function automatic logic [mch_pkg::MS_W-1:0] ms_step(
        input logic [mch_pkg::MS_W-1:0] v,
        input logic t
    );
        ms_step = (t && v != {mch_pkg::MS_W{1'b1}}) ? v + 16'h0001 : v;
    endfunction : ms_step

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        tick = (r.div == 16'(CLK_PER_MS - 1));
        next_r.div = tick ? 16'h0000 : r.div + 16'h0001;
        next_r.ms = ms_step(r.ms, tick);
        next_r.st.ring_seen = 1'b0;
        next_r.ring_prev = modem_in.ring;
        // ring watched in every state, terminal-ready or not
        if (modem_in.ring && !r.ring_prev) begin
            next_r.st.ring_seen = 1'b1;
        end
        if (modem_in.carrier_detect) begin
            next_r.carrier_seen = 1'b1;
        end

        // silence tracker, counted whether or not suppressors are disabled
        if (r.out.request_to_send || r.out.supervisory_tx || r.out.tone_2025) begin
            next_r.quiet_ms = '0;
        end else begin
            next_r.quiet_ms = ms_step(r.quiet_ms, tick);
        end

        case (r.state)
            mch_pkg::MCH_IDLE: begin
                next_r.out = '0;
                next_r.out.tx_marking = 1'b1;
                next_r.st = '0;
                next_r.st.ring_seen = modem_in.ring && !r.ring_prev;
                next_r.carrier_seen = 1'b0;
                next_r.suppressors_off = 1'b0;
                next_r.ms = '0;
                // answer a ringing call by raising terminal-ready
                if ((req.auto_answer && modem_in.ring) || req.call_out) begin
                    next_r.out.terminal_ready = 1'b1;
                    next_r.state = mch_pkg::MCH_ANSWER;
                end
            end
            mch_pkg::MCH_ANSWER: begin
                next_r.st.in_call = modem_in.set_ready;
                if (req.hangup) begin
                    next_r.state = mch_pkg::MCH_HANGUP_MARK;
                    next_r.ms = '0;
                end else if (modem_in.set_ready && req.call_out && req.reverse_channel
                             && !r.suppressors_off) begin
                    // caller disables suppressors with a tone
                    next_r.out.tone_2025 = 1'b1;
                    next_r.ms = '0;
                    next_r.state = mch_pkg::MCH_TONE;
                end else if (modem_in.set_ready && req.send_first) begin
                    next_r.out.request_to_send = 1'b1;
                    next_r.out.supervisory_tx = 1'b0;
                    next_r.state = mch_pkg::MCH_WAIT_CTS;
                end else if (modem_in.set_ready) begin
                    next_r.state = mch_pkg::MCH_RECEIVE;
                end
            end
            mch_pkg::MCH_TONE: begin
                // Strictly past the count: the first tick may come at once after entry
                if (r.ms > 16'(mch_pkg::TONE_MS)) begin
                    next_r.out.tone_2025 = 1'b0;
                    next_r.suppressors_off = 1'b1;
                    next_r.state = mch_pkg::MCH_RECEIVE;
                end
            end
            mch_pkg::MCH_WAIT_CTS: begin
                // no own timing, wait for the modem's clear-to-send
                // send on clear-to-send, needing supervisory data as well if gated
                if (req.hangup) begin
                    next_r.state = mch_pkg::MCH_HANGUP_MARK;
                    next_r.ms = '0;
                end else if (modem_in.clear_to_send &&
                             (!req.gate_on_supervisory || modem_in.supervisory_rx)) begin
                    next_r.out.tx_marking = 1'b0;
                    next_r.st.may_send = 1'b1;
                    next_r.state = mch_pkg::MCH_SEND;
                end
            end
            mch_pkg::MCH_SEND: begin
                // terminal sends end-of-message code, then flags msg_done
                // start-of-message code is the first thing terminal sends
                if (req.msg_done || req.hangup) begin
                    next_r.st.may_send = 1'b0;
                    next_r.out.tx_marking = 1'b1;
                    next_r.ms = '0;
                    next_r.state = req.hangup ? mch_pkg::MCH_HANGUP_MARK
                                              : mch_pkg::MCH_TURN_MARK;
                end
            end
            mch_pkg::MCH_TURN_MARK: begin
                // after the drop the modem squelches; we then just receive
                // One tick past the count, so the hold is never a part-tick short
                if (r.ms > 16'(mch_pkg::MARK_HOLD_MS)) begin
                    next_r.out.request_to_send = 1'b0;
                    next_r.state = mch_pkg::MCH_RECEIVE;
                end
            end
            mch_pkg::MCH_RECEIVE: begin
                // reverse channel only while request-to-send is off
                // keep reverse channel up as line keep-alive
                next_r.out.supervisory_tx = req.reverse_channel &&
                    (r.suppressors_off || r.quiet_ms >= 16'(mch_pkg::KEEPALIVE_MS));
                // abandon a call on which carrier never came
                if (!r.carrier_seen && modem_in.set_ready && !modem_in.carrier_detect
                    && r.ms >= 16'(NO_CARRIER_MS)) begin
                    next_r.st.abandoned = 1'b1;
                    next_r.out.supervisory_tx = 1'b0;
                    next_r.out.terminal_ready = 1'b0;
                    next_r.state = mch_pkg::MCH_IDLE;
                end else if (req.hangup || !modem_in.set_ready) begin
                    next_r.out.supervisory_tx = 1'b0;
                    next_r.ms = '0;
                    next_r.state = mch_pkg::MCH_HANGUP_GAP;
                end else if (req.end_of_message_code_received) begin
                    // modem's 200 ms clear-to-send delay is awaited
                    next_r.out.supervisory_tx = 1'b0;
                    next_r.out.request_to_send = 1'b1;
                    next_r.state = mch_pkg::MCH_WAIT_CTS;
                end
            end
            mch_pkg::MCH_HANGUP_MARK: begin
                next_r.st.may_send = 1'b0;
                next_r.out.tx_marking = 1'b1;
                next_r.out.supervisory_tx = 1'b0;
                next_r.out.tone_2025 = 1'b0;
                if (r.ms > 16'(mch_pkg::MARK_HOLD_MS)) begin
                    next_r.out.request_to_send = 1'b0;
                    next_r.ms = '0;
                    next_r.state = mch_pkg::MCH_HANGUP_GAP;
                end
            end
            mch_pkg::MCH_HANGUP_GAP: begin
                // terminal-ready drops 15 ms after request-to-send
                if (r.ms > 16'(mch_pkg::RTS_TO_DTR_MS)) begin
                    next_r.out.terminal_ready = 1'b0;
                    next_r.state = mch_pkg::MCH_IDLE;
                end
            end
            default: begin
                next_r.state = mch_pkg::MCH_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // every counter clears on reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.out.tx_marking <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign modem_out = r.out;
    assign stat = r.st;

endmodule : mch_sequencer

/* testbench/mch_sequencer_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Lead-sequence checker
// ----------------------------------------
module mch_sequencer_monitor #(
    parameter int unsigned CLK_PER_MS = 4,
    parameter int unsigned NO_CARRIER_MS = 50
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire mch_pkg::mch_modem_in_s modem_in,
    input wire mch_pkg::mch_req_s req,
    input wire mch_pkg::mch_modem_out_s modem_out,
    input wire mch_pkg::mch_stat_s stat
);
    int unsigned rts_lo, mark_c, tone_c;
    logic cd_ever;
    // Run lengths of lead states; no saturation, so only fit for short runs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {rts_lo, mark_c, tone_c, cd_ever} <= '0;
        end else begin
            rts_lo <= modem_out.request_to_send ? 0 : rts_lo + 1;
            mark_c <= modem_out.tx_marking ? mark_c + 1 : 0;
            tone_c <= modem_out.tone_2025 ? tone_c + 1 : 0;
            cd_ever <= modem_out.terminal_ready && (cd_ever || modem_in.carrier_detect);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_rev_rts_off: assert property (
        modem_out.supervisory_tx |-> !modem_out.request_to_send) else $error("rev with rts");
    chk_rts_on_ready: assert property (
        $rose(modem_in.set_ready) && req.send_first && modem_out.terminal_ready
        |=> modem_out.request_to_send) else $error("rts not raised on set ready");
    chk_send_on_cts: assert property ($rose(stat.may_send) |->
        $past(modem_in.clear_to_send) && (!$past(req.gate_on_supervisory)
        || $past(modem_in.supervisory_rx))) else $error("send allowed too early");
    chk_mark_hold: assert property (
        $fell(modem_out.request_to_send) |-> mark_c >= 15 * CLK_PER_MS - 1)
        else $error("rts dropped without marking hold");
    chk_dtr_gap: assert property (
        $fell(modem_out.terminal_ready) |-> rts_lo >= 15 * CLK_PER_MS - 1)
        else $error("dtr dropped too soon after rts");
    chk_rts_after_end: assert property ($rose(modem_out.request_to_send) |->
        $past(req.end_of_message_code_received) || ($past(modem_in.set_ready)
        && !$past(modem_in.set_ready, 2))) else $error("rts raised without cause");
    chk_abandon_cond: assert property (
        $rose(stat.abandoned) |-> !cd_ever && !modem_out.terminal_ready)
        else $error("abandon with carrier seen or dtr held");
    chk_tone_len: assert property ($fell(modem_out.tone_2025) |->
        tone_c >= 250 * CLK_PER_MS && tone_c <= 350 * CLK_PER_MS) else $error("tone length");
endmodule : mch_sequencer_monitor
bind mch_sequencer mch_sequencer_monitor #(.CLK_PER_MS(CLK_PER_MS),
    .NO_CARRIER_MS(NO_CARRIER_MS)) i_mch_sequencer_monitor (.sys_clk(sys_clk),
    .reset(reset), .modem_in(modem_in), .req(req), .modem_out(modem_out), .stat(stat));

/* testbench/mch_modem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Modem lead model
// ----------------------------------------
module mch_modem_model #(
    parameter int unsigned CPM = 4,
    parameter int unsigned SETUP_MS = 4000
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire mch_pkg::mch_modem_out_s modem_out,
    input wire logic ring_cmd,
    input wire logic rev_cmd,
    output mch_pkg::mch_modem_in_s modem_in
);
    int unsigned cts_c, on_c, off_c;
    logic first;
    logic sent;
    // timers clear on reset; only our own carrier is modelled
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {cts_c, on_c, off_c, first, sent, modem_in} <= '0;
        end else begin
            // ring follows the line whatever terminal-ready does
            modem_in.ring <= ring_cmd;
            // receiver squelched for 150 ms once our own transmitter stops
            modem_in.supervisory_rx <= rev_cmd && (modem_out.request_to_send || !sent
                || off_c >= 150 * CPM);
            if (modem_out.request_to_send) begin
                sent <= 1'b1;
            end
            modem_in.set_ready <= modem_out.terminal_ready;
            if (!modem_out.terminal_ready) begin
                first <= 1'b1;
            end
            // long delay on the first request of a call, short on turnaround
            if (!modem_out.request_to_send) begin
                cts_c <= 0;
                modem_in.clear_to_send <= 1'b0;
            end else if (cts_c >= (first ? SETUP_MS : 200) * CPM) begin
                modem_in.clear_to_send <= 1'b1;
                first <= 1'b0;
            end else begin
                cts_c <= cts_c + 1;
            end
            // clamp lifts after 40 ms, guard of 15 ms on loss
            if (modem_out.request_to_send) begin
                off_c <= 0;
                on_c <= on_c + 1;
                modem_in.carrier_detect <= modem_in.carrier_detect || on_c >= 40 * CPM;
            end else begin
                on_c <= 0;
                off_c <= off_c + 1;
                modem_in.carrier_detect <= modem_in.carrier_detect && off_c < 15 * CPM;
            end
        end
    end
endmodule : mch_modem_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Sequencer testbench
// ----------------------------------------
module testbench;
    localparam int CPM = 4;
    localparam int SETUP_MS = 60;
    localparam int NC_MS = 400;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic ring_cmd = 1'b0;
    logic rev_cmd = 1'b0;
    mch_pkg::mch_req_s req = '0;
    mch_pkg::mch_modem_in_s mi;
    mch_pkg::mch_modem_out_s mo;
    mch_pkg::mch_stat_s st;
    int err_count = 0;
    int cmp_count = 0;
    int seed = 32'hc9a3;
    int d;
    // Free-running 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    mch_sequencer #(.CLK_PER_MS(CPM), .NO_CARRIER_MS(NC_MS)) i_mch_sequencer (.sys_clk(sys_clk),
        .reset(reset), .modem_in(mi), .req(req), .modem_out(mo), .stat(st));
    mch_modem_model #(.CPM(CPM), .SETUP_MS(SETUP_MS)) i_mch_modem_model (.sys_clk(sys_clk),
        .reset(reset), .modem_out(mo), .ring_cmd(ring_cmd), .rev_cmd(rev_cmd), .modem_in(mi));
    function automatic logic sig(input int s);
        case (s)
            0: return mo.terminal_ready;
            1: return mo.request_to_send;
            2: return st.may_send;
            3: return mo.tone_2025;
            4: return st.abandoned;
            default: return mi.clear_to_send;
        endcase
    endfunction : sig
    task automatic check(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check
    // Cycles until a lead reaches a level, compared with the expected window
    task automatic span(input int s, input logic v, input int lo, input int hi, input string m);
        int n;
        n = 0;
        #1;
        while (sig(s) !== v && n < 5000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(sig(s) === v && n >= lo && n <= hi, m);
    endtask : span
    task automatic pulse(input int b);
        @(posedge sys_clk);
        req[b] <= 1'b1;
        @(posedge sys_clk);
        req[b] <= 1'b0;
    endtask : pulse
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence: unattended answer and turnaround, then abandoned call
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        d = {$random(seed)} % 64;
        @(posedge sys_clk);
        ring_cmd <= 1'b1;
        req <= 8'hd0; // auto answer, send first, gated on reverse channel
        span(0, 1'b1, 0, 4, "no answer");
        check(st.ring_seen === 1'b1, "ring pulse missing");
        span(1, 1'b1, 0, 3, "rts late");
        check(st.in_call === 1'b1, "in call not shown");
        span(5, 1'b1, SETUP_MS * CPM, SETUP_MS * CPM + 3, "cts set-up");
        repeat (d + 1) @(posedge sys_clk);
        check(st.may_send === 1'b0, "sent without reverse");
        rev_cmd <= 1'b1;
        span(2, 1'b1, 0, 4, "may_send late");
        check(mo.tx_marking === 1'b0, "still marking while sending");
        pulse(3);
        span(1, 1'b0, 15 * CPM - 2, 17 * CPM, "marking hold");
        check(mo.tx_marking === 1'b1, "not marking at rts drop");
        pulse(2);
        span(1, 1'b1, 0, 3, "rts after end of message");
        span(2, 1'b1, 200 * CPM, 200 * CPM + 5, "turnaround");
        pulse(1);
        span(1, 1'b0, 15 * CPM - 2, 17 * CPM, "hangup marking");
        @(posedge sys_clk);
        req <= '0;
        ring_cmd <= 1'b0;
        span(0, 1'b0, 15 * CPM - 2, 17 * CPM, "dtr gap");
        @(posedge sys_clk);
        req <= 8'h21; // reverse channel, call placed and held as a level
        span(3, 1'b1, 0, 8, "no tone");
        span(3, 1'b0, 300 * CPM, 301 * CPM + 2, "tone length");
        repeat (2) @(posedge sys_clk);
        check(mo.supervisory_tx === 1'b1 && mo.request_to_send === 1'b0, "keep-alive");
        span(4, 1'b1, 0, (NC_MS - 300 + 2) * CPM, "no abandon");
        check(mo.terminal_ready === 1'b0, "dtr held");
        tally_and_finish();
    end
    // Watchdog against a hung sequence
    initial begin
        repeat (10000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end
endmodule : testbench
